/* src/adc_ctrl_map.vh */
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

`define ADC_ADDR_W 4
`define ADC_DATA_W 16

`define ADC_REG_CTRL 4'h0
`define ADC_REG_MUX 4'h1
`define ADC_REG_RESULT 4'h2
`define ADC_REG_WIN_LO 4'h3
`define ADC_REG_WIN_HI 4'h4
`define ADC_REG_STATUS 4'h5
`define ADC_REG_MASK 4'h6

`define CTRL_ENABLE_BIT 0
`define CTRL_SRC_LSB 1
`define CTRL_SRC_MSB 3
`define CTRL_WIN_INSIDE_BIT 4
`define CTRL_BACKGROUND_BIT 5
`define CTRL_SW_START_BIT 6

`define MUX_POS_LSB 0
`define MUX_POS_MSB 4
`define MUX_NEG_LSB 5
`define MUX_NEG_MSB 9

`define STAT_DONE_BIT 0
`define STAT_WIN_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_EVENTS 2

`define SRC_SOFTWARE 3'h0
`define SRC_TIMER0 3'h1
`define SRC_TIMER1 3'h2
`define SRC_TIMER2 3'h3
`define SRC_TIMER3 3'h4
`define SRC_EXT_PIN 3'h5

`define CHAN_W 5
`define CHAN_LAST 5'h14
`define RESULT_W 10

`define CTRL_RESET 16'h0000
`define MUX_RESET 16'h0000
`define WIN_LO_RESET 10'h000
`define WIN_HI_RESET 10'h3FF
`define MASK_RESET 2'h0

`define CLK_PERIOD_NS 10
`define CONV_PERIOD_NS 5000
`define CONV_CYCLES ((`CONV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPACING_W 10

`endif

/* src/pin_edge_detect.v */
// Two-flop synchroniser with rising edge detector for the convert-start pin
`timescale 1ns/1ns
module pin_edge_detect (
  input wire clk_sys, // System clock
  input wire rst, // Synchronous reset, active high
  input wire pin_in, // Raw pin level
  output reg rise_pulse // One-cycle pulse per rising edge
);
  reg sync_a;
  reg sync_b;
  reg sync_prev;

  // First stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_prev <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      sync_prev <= sync_b;
      rise_pulse <= sync_b & ~sync_prev; // see R9
    end
  end
endmodule

/* src/sar_adc_conversion_control.v */
// Conversion control, result capture and window compare for a 10-bit SAR converter
`timescale 1ns/1ns
`include "adc_ctrl_map.vh"

// Summary of operation
// R1 - Start from software, four timers, or pin
// R2 - Completion sets flag; interrupt only if enabled
// R3 - Whole 10-bit result captured at once
// R4 - Window interrupt on inside or outside range
// R5 - Background mode repeats, interrupts only on window
// R6 - Separate positive and negative channel selects
// R7 - Firmware shutdown powers the converter down
// R8 - Back-to-back conversions up to 200 ksps
// R9 - Pin synchronised, one conversion per edge
module sar_adc_conversion_control (
  input wire clk_sys, // System clock, 100 MHz
  input wire rst, // Synchronous reset, active high
  input wire [`ADC_ADDR_W-1:0] reg_addr, // Register index
  input wire [`ADC_DATA_W-1:0] reg_wdata, // Write data
  input wire reg_write, // Write strobe
  input wire reg_read, // Read strobe
  output reg [`ADC_DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  input wire [3:0] timer_overflow, // Timer 0..3 overflow pulses
  input wire ext_convert_start_pin, // External convert-start pin
  input wire adc_done, // Core finished, one-cycle pulse
  input wire [`RESULT_W-1:0] adc_result, // Core result, valid with adc_done
  output reg adc_start, // Start pulse to core
  output reg [`CHAN_W-1:0] adc_pos_sel, // Positive input select
  output reg [`CHAN_W-1:0] adc_neg_sel, // Negative input select
  output reg adc_power_down, // Converter shutdown
  output reg irq // Level interrupt
);
  localparam ST_IDLE = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_CONV = 2'b10;

  // Reset images of the control and channel registers, sliced per field below
  localparam [`ADC_DATA_W-1:0] CTRL_INIT = `CTRL_RESET;
  localparam [`ADC_DATA_W-1:0] MUX_INIT = `MUX_RESET;

  // Spacing counts from the full load down to zero, one start per period
  localparam integer SPACING_FULL = `CONV_CYCLES - 1;
  localparam [`SPACING_W-1:0] SPACING_LOAD = SPACING_FULL[`SPACING_W-1:0];

  reg [1:0] state;
  reg [1:0] next_state;
  reg enable;
  reg [2:0] start_src;
  reg win_inside;
  reg background;
  reg sw_start;
  reg [`CHAN_W-1:0] pos_chan;
  reg [`CHAN_W-1:0] neg_chan;
  reg [`RESULT_W-1:0] result;
  reg [`RESULT_W-1:0] win_lo;
  reg [`RESULT_W-1:0] win_hi;
  reg [`STAT_EVENTS-1:0] status;
  reg [`STAT_EVENTS-1:0] mask;
  reg [`SPACING_W-1:0] spacing;
  reg trigger;

  wire pin_rise;
  wire wr_ctrl;
  wire wr_status;
  wire conv_end;
  wire in_window;
  wire win_hit;
  wire spacing_done;
  wire [`STAT_EVENTS-1:0] event_set;
  // Per-event gate ahead of the mask; done drops out in background mode
  wire [`STAT_EVENTS-1:0] irq_gate;

  // Pin edges arrive as one-cycle pulses three clocks after the pin rises
  pin_edge_detect u_pin_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(ext_convert_start_pin),
    .rise_pulse(pin_rise)
  );

  assign wr_ctrl = reg_write && (reg_addr == `ADC_REG_CTRL);
  assign wr_status = reg_write && (reg_addr == `ADC_REG_STATUS);
  assign conv_end = (state == ST_CONV) && adc_done;
  assign spacing_done = (spacing == {`SPACING_W{1'b0}});

  // Inclusive bounds on both ends; crossed bounds (low above high)
  // leave nothing inside, so outside mode then flags every result
  assign in_window = (adc_result >= win_lo) && (adc_result <= win_hi);
  assign win_hit = win_inside ? in_window : ~in_window; // see R4

  assign event_set[`STAT_DONE_BIT] = conv_end; // see R2
  assign event_set[`STAT_WIN_BIT] = conv_end && win_hit; // see R4

  // Background mode keeps completion out of the interrupt path
  assign irq_gate[`STAT_DONE_BIT] = ~background; // see R5
  assign irq_gate[`STAT_WIN_BIT] = 1'b1;

  // Control register; software start is a self-clearing pulse
  always @(posedge clk_sys) begin
    if (rst) begin
      enable <= CTRL_INIT[`CTRL_ENABLE_BIT];
      start_src <= CTRL_INIT[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
      win_inside <= CTRL_INIT[`CTRL_WIN_INSIDE_BIT];
      background <= CTRL_INIT[`CTRL_BACKGROUND_BIT];
      sw_start <= 1'b0;
    end else begin
      sw_start <= wr_ctrl && reg_wdata[`CTRL_SW_START_BIT];
      if (wr_ctrl) begin
        enable <= reg_wdata[`CTRL_ENABLE_BIT];
        start_src <= reg_wdata[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
        win_inside <= reg_wdata[`CTRL_WIN_INSIDE_BIT];
        background <= reg_wdata[`CTRL_BACKGROUND_BIT];
      end
    end
  end

  // Channel selects, window bounds and mask
  always @(posedge clk_sys) begin
    if (rst) begin
      pos_chan <= MUX_INIT[`MUX_POS_MSB:`MUX_POS_LSB];
      neg_chan <= MUX_INIT[`MUX_NEG_MSB:`MUX_NEG_LSB];
      win_lo <= `WIN_LO_RESET;
      win_hi <= `WIN_HI_RESET;
      mask <= `MASK_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        `ADC_REG_MUX: begin
          pos_chan <= reg_wdata[`MUX_POS_MSB:`MUX_POS_LSB]; // see R6
          neg_chan <= reg_wdata[`MUX_NEG_MSB:`MUX_NEG_LSB]; // see R6
        end
        `ADC_REG_WIN_LO: begin
          win_lo <= reg_wdata[`RESULT_W-1:0];
        end
        `ADC_REG_WIN_HI: begin
          win_hi <= reg_wdata[`RESULT_W-1:0];
        end
        `ADC_REG_MASK: begin
          mask <= reg_wdata[`STAT_EVENTS-1:0];
        end
        default: begin
          mask <= mask;
        end
      endcase
    end
  end

  // Start source selection
  always @* begin
    case (start_src)
      `SRC_SOFTWARE: trigger = sw_start; // see R1
      `SRC_TIMER0: trigger = timer_overflow[0]; // see R1
      `SRC_TIMER1: trigger = timer_overflow[1]; // see R1
      `SRC_TIMER2: trigger = timer_overflow[2]; // see R1
      `SRC_TIMER3: trigger = timer_overflow[3]; // see R1
      `SRC_EXT_PIN: trigger = pin_rise; // see R9
      // Codes 6 and 7 select no source and never trigger; only background mode still starts conversions
      default: trigger = 1'b0;
    endcase
  end

  // Sequencer. Triggers arriving while busy or too early are dropped, not queued,
  // so a burst of edges cannot overrun the core.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (enable && spacing_done && (trigger || background)) begin
          next_state = ST_START; // see R1
        end
      end
      ST_START: begin
        next_state = ST_CONV;
      end
      ST_CONV: begin
        if (adc_done) begin
          next_state = ST_IDLE; // see R8
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Shutdown overrides every state and abandons a conversion in flight
    if (!enable) begin
      next_state = ST_IDLE; // see R7
    end
  end

  // An unused state code recovers to idle through the default branch
  always @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Start spacing holds the rate at the converter's throughput ceiling
  // A trigger inside the period is dropped rather than held back
  always @(posedge clk_sys) begin
    if (rst) begin
      spacing <= {`SPACING_W{1'b0}};
    end else if (state == ST_START) begin
      spacing <= SPACING_LOAD; // see R8
    end else if (!spacing_done) begin
      spacing <= spacing - 1'b1;
    end
  end

  // Core-facing outputs
  always @(posedge clk_sys) begin
    if (rst) begin
      adc_start <= 1'b0;
      adc_pos_sel <= MUX_INIT[`MUX_POS_MSB:`MUX_POS_LSB];
      adc_neg_sel <= MUX_INIT[`MUX_NEG_MSB:`MUX_NEG_LSB];
      // Converter stays off until software sets the enable bit
      adc_power_down <= ~CTRL_INIT[`CTRL_ENABLE_BIT];
    end else begin
      adc_start <= (next_state == ST_START) && (state == ST_IDLE);
      adc_pos_sel <= pos_chan; // see R6
      adc_neg_sel <= neg_chan; // see R6
      adc_power_down <= ~enable; // see R7
    end
  end

  // Result held until the next completion; all ten bits load together
  always @(posedge clk_sys) begin
    if (rst) begin
      result <= {`RESULT_W{1'b0}};
    end else if (conv_end) begin
      result <= adc_result; // see R3
    end
  end

  // Sticky status, write one to clear; a new event beats a clear
  genvar gi;
  generate
    for (gi = 0; gi < `STAT_EVENTS; gi = gi + 1) begin : g_status
      always @(posedge clk_sys) begin
        if (rst) begin
          status[gi] <= 1'b0;
        end else if (event_set[gi]) begin
          status[gi] <= 1'b1; // see R2
        end else if (wr_status && reg_wdata[gi]) begin
          status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Registered so the pin cannot glitch when status and mask change together
  always @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask & irq_gate); // see R2 see R5
    end
  end

  // Read port; unmapped indices read zero
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= {`ADC_DATA_W{1'b0}};
    end else if (reg_read) begin
      reg_rdata <= {`ADC_DATA_W{1'b0}};
      case (reg_addr)
        `ADC_REG_CTRL: begin
          reg_rdata[`CTRL_ENABLE_BIT] <= enable;
          reg_rdata[`CTRL_SRC_MSB:`CTRL_SRC_LSB] <= start_src;
          reg_rdata[`CTRL_WIN_INSIDE_BIT] <= win_inside;
          reg_rdata[`CTRL_BACKGROUND_BIT] <= background;
        end
        `ADC_REG_MUX: begin
          reg_rdata[`MUX_POS_MSB:`MUX_POS_LSB] <= pos_chan;
          reg_rdata[`MUX_NEG_MSB:`MUX_NEG_LSB] <= neg_chan;
        end
        `ADC_REG_RESULT: begin
          reg_rdata[`RESULT_W-1:0] <= result; // see R3
        end
        `ADC_REG_WIN_LO: begin
          reg_rdata[`RESULT_W-1:0] <= win_lo;
        end
        `ADC_REG_WIN_HI: begin
          reg_rdata[`RESULT_W-1:0] <= win_hi;
        end
        `ADC_REG_STATUS: begin
          reg_rdata[`STAT_EVENTS-1:0] <= status;
          // Busy is live state, not a sticky event, and ignores clears
          reg_rdata[`STAT_BUSY_BIT] <= (state != ST_IDLE);
        end
        `ADC_REG_MASK: begin
          reg_rdata[`STAT_EVENTS-1:0] <= mask;
        end
        default: begin
          reg_rdata <= {`ADC_DATA_W{1'b0}};
        end
      endcase
    end else begin
      reg_rdata <= {`ADC_DATA_W{1'b0}};
    end
  end
endmodule

/* tb/adc_ctrl_sva.sv */
// Assertion checker for the converter control ports
`timescale 1ns/1ns
module adc_ctrl_sva (
  input wire clk_sys, // Clock
  input wire rst, // Reset
  input wire [3:0] reg_addr, // Index
  input wire [15:0] reg_wdata, // Wdata
  input wire reg_write, // Write
  input wire reg_read, // Read
  input wire [15:0] reg_rdata, // Rdata
  input wire adc_done, // Done
  input wire adc_start, // Start
  input wire [4:0] adc_pos_sel, // Pos
  input wire [4:0] adc_neg_sel, // Neg
  input wire adc_power_down, // Off
  input wire irq // Irq
);
  reg [8:0] gap;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles left before the throughput limit allows another start
  always @(posedge clk_sys) begin
    if (rst)
      gap <= 9'h000;
    else if (adc_start)
      gap <= 9'h1F3;
    else if (gap != 9'h000)
      gap <= gap - 9'h001;
  end
  a_start_pulse: assert property (adc_start |=> !adc_start) else $error("long start");
  a_start_spacing: assert property (adc_start |-> gap == 9'h000) else $error("starts too close");
  a_start_powered: assert property (adc_start |-> !adc_power_down) else $error("start while off");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000) else $error("stray rdata");
  a_reset_state: assert property ($fell(rst) |-> adc_power_down && !irq && !adc_start) else $error("reset");
  a_sel_follow: assert property (reg_write && reg_addr == 4'h1 |-> ##2
    {6'h00, adc_neg_sel, adc_pos_sel} == ($past(reg_wdata, 2) & 16'h03FF)) else $error("select");
  a_irq_cause: assert property ($rose(irq) |-> $past(adc_done, 2) || $past(reg_write, 2)) else $error("irq rise");
  a_irq_drop: assert property ($fell(irq) |-> $past(reg_write, 2)) else $error("irq fall");
  c_start: cover property (adc_start);
  c_irq: cover property ($rose(irq));
  c_read: cover property (reg_read ##1 reg_rdata != 16'h0000);
endmodule
bind sar_adc_conversion_control adc_ctrl_sva chk (.*);

/* tb/sar_adc_conversion_control_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module sar_adc_conversion_control_tb;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg [3:0] timer_overflow = 4'h0;
  reg ext_convert_start_pin = 1'b0;
  reg [9:0] conv_value = 10'h000;
  reg [7:0] conv_lat = 8'h10;
  wire [15:0] reg_rdata;
  wire adc_done, adc_start, adc_power_down, irq;
  wire [9:0] adc_result;
  wire [4:0] adc_pos_sel, adc_neg_sel;
  int n_mismatch = 0, comparisons = 0, n_starts = 0, cycles = 0;
  bit pend = 0;
  logic [15:0] expq[$];
  sar_adc_conversion_control dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .timer_overflow(timer_overflow),
    .ext_convert_start_pin(ext_convert_start_pin),
    .adc_done(adc_done),
    .adc_result(adc_result),
    .adc_start(adc_start),
    .adc_pos_sel(adc_pos_sel),
    .adc_neg_sel(adc_neg_sel),
    .adc_power_down(adc_power_down),
    .irq(irq)
  );
  sar_core_model core (
    .clk_sys(clk_sys),
    .rst(rst),
    .adc_start(adc_start),
    .conv_value(conv_value),
    .conv_lat(conv_lat),
    .adc_done(adc_done),
    .adc_result(adc_result)
  );
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    expq.push_back(e);
    @(posedge clk_sys);
    reg_read <= 1'b0;
  endtask
  task fire(input [15:0] c);
    @(posedge clk_sys);
    if (c[3:1] == 3'h0)
      wr(4'h0, c | 16'h0040);
    else if (c[3:1] == 3'h5)
      ext_convert_start_pin <= 1'b1;
    else begin
      timer_overflow[c[3:1] - 3'h1] <= 1'b1;
      @(posedge clk_sys);
      timer_overflow <= 4'h0;
    end
  endtask
  task finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Read data are due one cycle after each strobe, in order
  always @(posedge clk_sys) begin
    cycles++;
    if (adc_start === 1'b1)
      n_starts++;
    if (pend)
      chk(reg_rdata === expq.pop_front(), "read data");
    pend = reg_read;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    logic [15:0] c;
    logic [9:0] v;
    bit hit;
    int s0, k;
    void'($urandom(64));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h03FF);
    rd(4'hF, 16'h0000);
    c = {6'h00, 5'($urandom % 21), 5'h14};
    wr(4'h1, c);
    rd(4'h1, c);
    chk({adc_neg_sel, adc_pos_sel} === c[9:0], "select");
    wr(4'h3, 16'h0100);
    wr(4'h4, 16'h02FF);
    rd(4'h3, 16'h0100);
    // One pass per start source; odd passes look inside the window
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 10'h100 : 10'($urandom);
      conv_value <= v;
      conv_lat <= 8'(10 + $urandom % 200);
      hit = (v >= 10'h100 && v <= 10'h2FF) ^ !i[0];
      c = {11'h000, i[0], 3'(i), 1'b1};
      wr(4'h6, {14'h0000, i[1], !i[2]});
      wr(4'h0, c);
      s0 = n_starts;
      fire(c);
      fire(c); // Second software or timer trigger lands while busy
      for (k = 0; k < 300 && adc_done !== 1'b1; k++)
        @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      chk(irq === (!i[2] | (hit & i[1])), "irq");
      rd(4'h2, {6'h00, v});
      rd(4'h5, {14'h0000, hit, 1'b1});
      wr(4'h5, 16'h0003);
      rd(4'h5, 16'h0000);
      repeat (500) @(posedge clk_sys);
      chk(n_starts == s0 + 1, "start count");
      ext_convert_start_pin <= 1'b0;
    end
    // Code 6 names no source: neither timers nor a software start may fire
    s0 = n_starts;
    wr(4'h0, 16'h004D);
    timer_overflow <= 4'hF;
    @(posedge clk_sys);
    timer_overflow <= 4'h0;
    repeat (8) @(posedge clk_sys);
    chk(n_starts == s0, "unused source");
    rd(4'h0, 16'h000D);
    conv_value <= 10'h050;
    wr(4'h6, 16'h0003);
    rd(4'h6, 16'h0003);
    wr(4'h0, 16'h0031);
    s0 = n_starts;
    for (k = 0; k < 1600 && irq !== 1'b1; k++)
      @(posedge clk_sys);
    chk(irq === 1'b0 && n_starts > s0 + 2, "background");
    conv_value <= 10'h180;
    for (k = 0; k < 1200 && irq !== 1'b1; k++)
      @(posedge clk_sys);
    rd(4'h5, 16'h0003);
    wr(4'h0, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk(adc_power_down === 1'b1, "shutdown");
    finish_test();
  end
endmodule

/* tb/sar_core_model.sv */
// Behavioural model of the analog converter core
`timescale 1ns/1ns
module sar_core_model (
  input wire clk_sys, // Clock
  input wire rst, // Reset
  input wire adc_start, // Start pulse
  input wire [9:0] conv_value, // Value to return
  input wire [7:0] conv_lat, // Conversion cycles
  output reg adc_done, // Done pulse
  output reg [9:0] adc_result // Valid with done
);
  reg [8:0] cnt;
  always @(posedge clk_sys) begin
    // Result toggles outside the done slot so a stale value cannot pass
    adc_result <= rst ? 10'h2AA : (cnt == 9'h001 ? conv_value : ~adc_result);
    adc_done <= !rst && cnt == 9'h001;
    if (rst)
      cnt <= 9'h000;
    else if (adc_start)
      cnt <= {1'b0, conv_lat} + 9'h001;
    else if (cnt != 9'h000)
      cnt <= cnt - 9'h001;
  end
endmodule
